// *** rtl/fls_cfg.svh ***
// Constants for the flash lock-bit sequencing controller
`ifndef FLS_CFG_SVH
`define FLS_CFG_SVH
// Flash command codes
`define FLS_CMD_LOCK_SETUP   8'h60
`define FLS_CMD_BLOCK_CONF   8'h01
`define FLS_CMD_MASTER_CONF  8'hf1
`define FLS_CMD_READ_ARRAY   8'hff
`define FLS_CMD_CLEAR_STATUS 8'h50
`define FLS_CMD_READ_STATUS  8'h70
// Flash status bit positions
`define FLS_SB_READY   7
`define FLS_SB_ERASE   5
`define FLS_SB_WRITE   4
`define FLS_SB_SUPPLY  3
`define FLS_SB_PROTECT 1
// APB register byte offsets
`define FLS_REG_CTRL   12'h000
`define FLS_REG_ADDR   12'h004
`define FLS_REG_STAT   12'h008
`define FLS_REG_FSTAT  12'h00c
`define FLS_REG_IRQ    12'h010
`define FLS_REG_MASK   12'h014
// Control register fields
`define FLS_CTRL_GO     0
`define FLS_CTRL_MASTER 1
`define FLS_CTRL_CLEAR  2
`define FLS_CTRL_ARRAY  3
// Interrupt status bits
`define FLS_IRQ_DONE  0
`define FLS_IRQ_ERROR 1
// Bus cycle timing on the flash pins, in ns and in pclk cycles
`define FLS_CLK_NS     25
`define FLS_STROBE_NS  100
`define FLS_STROBE_CYC ((`FLS_STROBE_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`endif

// *** rtl/fls_pkg.sv ***
// Types for the flash lock-bit sequencing controller
package fls_pkg;
   typedef enum logic [3:0] {
      FLS_IDLE, FLS_W1, FLS_W1_GAP, FLS_W2, FLS_W2_GAP,
      FLS_WAIT, FLS_RD, FLS_RD_HOLD, FLS_DONE
   } fls_state_type;
   typedef enum logic [1:0] {
      FLS_OP_LOCK, FLS_OP_CLEAR, FLS_OP_ARRAY
   } fls_op_type;
endpackage

// *** rtl/fls_strobe.sv ***
// Strobe timer: holds a write or read strobe active for a fixed cycle count
`timescale 1ns/100ps
`include "fls_cfg.svh"
module fls_strobe #(
   parameter int CYCLES = `FLS_STROBE_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [7:0] count;
   wire        last = (count == 8'h01);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
      end else if (start) begin
         count <= 8'(CYCLES);
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
      end
   end
   assign busy = (count != 8'h00);
   assign done = busy && last;
endmodule

// *** rtl/fls_ctrl.sv ***
// Host-side controller that sets flash lock bits and checks status over the flash pins
//
// Functional notes
// - Lock setup 60h, then 01h at block address or f1h for master.
// - Several sequences may run back to back; error check kept sticky across them.
// - Writing ffh after the last sequence returns the flash to read array.
// - Clear status is issued before any retry after an error; here 50h goes out only on a host write of the CTRL clear bit.
`timescale 1ns/100ps
`include "fls_cfg.svh"
module fls_ctrl
   import fls_pkg::*;
#(
   parameter int ADDR_W = 21
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_in,
   output logic                   flash_ce_n,
   output logic                   flash_we_n,
   output logic                   flash_oe_n,
   input  wire logic              done_line_n
);
   import fls_pkg::*;
   fls_state_type     state;
   fls_op_type        op;
   logic              master;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0]        fstat;
   logic [7:0]        sticky;
   logic [1:0]        irq_stat;
   logic [1:0]        irq_mask;
   logic [7:0]        conf_code;
   logic              st_start;
   logic              st_busy;
   logic              st_done;
   logic              pending_clear;

   fls_strobe u_strobe (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (st_start),
      .busy    (st_busy),
      .done    (st_done)
   );

   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire idle     = (state == FLS_IDLE);
   wire wr_ctrl  = wr && (paddr == `FLS_REG_CTRL) && idle;
   wire wr_addr  = wr && (paddr == `FLS_REG_ADDR);
   wire wr_irq   = wr && (paddr == `FLS_REG_IRQ);
   wire wr_mask  = wr && (paddr == `FLS_REG_MASK);
   wire mapped   = (paddr <= `FLS_REG_MASK) && (paddr[1:0] == 2'b00);
   wire go       = wr_ctrl && pwdata[`FLS_CTRL_GO];
   wire go_clear = wr_ctrl && pwdata[`FLS_CTRL_CLEAR];
   wire go_array = wr_ctrl && pwdata[`FLS_CTRL_ARRAY];
   // Status bit 0 masked off
   wire [7:0] rd_stat = flash_dq_in & 8'hfe;
   // Sequence error taken from the held status, not the live bus
   wire err_seq  = fstat[`FLS_SB_WRITE] && fstat[`FLS_SB_ERASE];
   wire [7:0] err_bits = ((state == FLS_RD) && st_done) ? (rd_stat & 8'h3a) : 8'h00;
   wire any_err  = |rd_stat[`FLS_SB_ERASE:`FLS_SB_PROTECT];
   wire is_lock  = (op == FLS_OP_LOCK);

   // Confirm code for block or master lock
   assign conf_code = master ? `FLS_CMD_MASTER_CONF : `FLS_CMD_BLOCK_CONF;
   assign st_start  = !st_busy && (state == FLS_W1 || state == FLS_W2 || state == FLS_RD)
                      && flash_ce_n;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign irq     = |(irq_stat & irq_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FLS_IDLE;
      end else begin
         unique case (state)
            FLS_IDLE:    if (go || go_clear || go_array) state <= FLS_W1;
            FLS_W1:      if (st_done) state <= FLS_W1_GAP;
            FLS_W1_GAP:  state <= is_lock ? FLS_W2 : FLS_DONE;
            FLS_W2:      if (st_done) state <= FLS_W2_GAP;
            FLS_W2_GAP:  state <= FLS_WAIT;
            // Wait on done line, not polling
            FLS_WAIT:    if (done_line_n) state <= FLS_RD;
            FLS_RD:      if (st_done) state <= FLS_RD_HOLD;
            FLS_RD_HOLD: state <= FLS_DONE;
            FLS_DONE:    state <= FLS_IDLE;
            default:     state <= FLS_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op       <= FLS_OP_LOCK;
         master   <= 1'b0;
         addr_reg <= '0;
      end else begin
         if (go) op <= FLS_OP_LOCK;
         else if (go_clear) op <= FLS_OP_CLEAR;
         else if (go_array) op <= FLS_OP_ARRAY;
         if (wr_ctrl) master <= pwdata[`FLS_CTRL_MASTER];
         if (wr_addr) addr_reg <= pwdata[ADDR_W-1:0];
      end
   end

   // Pin drive, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_ce_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_dq_oe  <= 1'b0;
         flash_dq_out <= 8'h00;
         flash_addr   <= '0;
      end else begin
         flash_addr <= addr_reg;
         if (st_start) begin
            flash_ce_n  <= 1'b0;
            flash_we_n  <= (state == FLS_RD);
            flash_oe_n  <= (state != FLS_RD);
            flash_dq_oe <= (state != FLS_RD);
            // Array restore uses ffh; clear status before retry
            unique case (state)
               FLS_W1: flash_dq_out <= (op == FLS_OP_LOCK)  ? `FLS_CMD_LOCK_SETUP :
                                       (op == FLS_OP_CLEAR) ? `FLS_CMD_CLEAR_STATUS :
                                                              `FLS_CMD_READ_ARRAY;
               FLS_W2: flash_dq_out <= conf_code;
               default: flash_dq_out <= flash_dq_out;
            endcase
         end else if (st_done) begin
            flash_ce_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
         end else if (flash_ce_n) begin
            flash_dq_oe <= 1'b0;
         end
      end
   end

   // Status read taken after lock completes; bit 7 ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fstat         <= 8'h00;
         sticky        <= 8'h00;
         pending_clear <= 1'b0;
      end else begin
         pending_clear <= go_clear;
         if (state == FLS_RD && st_done && rd_stat[`FLS_SB_READY]) begin
            fstat <= rd_stat;
         end
         // Sticky until clear; set wins over clear
         sticky <= (pending_clear ? 8'h00 : sticky) | err_bits;
      end
   end

   wire ev_done = (state == FLS_DONE);
   wire ev_err  = (state == FLS_RD) && st_done && any_err;
   wire [1:0] irq_events = {ev_err, ev_done};
   // Set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 2'b00;
         irq_mask <= 2'b00;
      end else begin
         irq_stat <= (irq_stat & ~(wr_irq ? pwdata[1:0] : 2'b00)) | irq_events;
         if (wr_mask) irq_mask <= pwdata[1:0];
      end
   end

   always_comb begin
      unique case (paddr)
         `FLS_REG_CTRL:  prdata = {31'h0, !idle};
         `FLS_REG_ADDR:  prdata = {{(32-ADDR_W){1'b0}}, addr_reg};
         `FLS_REG_STAT:  prdata = {22'h0, err_seq, done_line_n, sticky};
         `FLS_REG_FSTAT: prdata = {24'h0, fstat};
         `FLS_REG_IRQ:   prdata = {30'h0, irq_stat};
         `FLS_REG_MASK:  prdata = {30'h0, irq_mask};
         default:        prdata = 32'h0;
      endcase
   end

   // Sequence shape on the flash pins
   sequence write_low_s;
      !flash_we_n && !flash_ce_n;
   endsequence

   setup_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == FLS_W2 && st_start) |-> flash_dq_out == `FLS_CMD_LOCK_SETUP)
      else $error("confirm without setup code");
   confirm_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == FLS_W2 && st_start) |=> write_low_s ##0 (flash_dq_out == conf_code))
      else $error("bad confirm code");
   // No status read while done line low
   wait_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == FLS_WAIT && !done_line_n) |=> state == FLS_WAIT)
      else $error("left wait while flash busy");
   sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !pending_clear |=> (sticky & $past(sticky)) == $past(sticky))
      else $error("sticky bit lost");
   clear_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      go_clear |=> ##1 sticky == 8'h00)
      else $error("clear did not empty sticky");
   strobe_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(flash_ce_n) |-> !flash_ce_n [*2])
      else $error("strobe too short");
   irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_events != 2'b00) |=> (irq_stat & $past(irq_events)) == $past(irq_events))
      else $error("irq event lost");
   no_drive_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
      !flash_oe_n |-> !flash_dq_oe)
      else $error("bus contention on read");
endmodule

// *** bench/fls_flash_model.sv ***
// Behavioural flash: command decoder, master lock bit, status word and done line
`timescale 1ns/100ps
module fls_flash_model #(
   parameter int BUSY = 20
) (
   input  wire logic        pclk,
   input  wire logic [20:0] flash_addr,
   input  wire logic [7:0]  flash_dq_out,
   input  wire logic        flash_dq_oe,
   output logic [7:0]       flash_dq_in,
   input  wire logic        flash_ce_n,
   input  wire logic        flash_we_n,
   input  wire logic        flash_oe_n,
   output logic             done_line_n,
   input  wire logic        override_high_level,
   input  wire logic        bad_seq,
   input  wire logic        low_supply
);
   logic [7:0]  wd = 8'h00, err = 8'h00, last = 8'h00, operation_status;
   logic [20:0] wa = 21'h0;
   logic        wact = 0, setup = 0, smode = 0, master = 0;
   int          cnt = 0, nops = 0;
   assign done_line_n = (cnt == 0);
   // ready bit; reserved bit high so masking shows
   assign operation_status = {done_line_n, 1'b0, err[5:1], 1'b1};
   // Released bus shows the inverse of the last value
   assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ?
                        (smode ? operation_status : wa[7:0]) : ~last;
   always @(posedge pclk) begin
      last <= flash_dq_in;
      if (cnt > 0) cnt <= cnt - 1;
      if (!flash_ce_n && !flash_we_n) begin
         // Undriven data reads as zero, so a missing enable turns into a bad command
         wd <= flash_dq_oe ? flash_dq_out : 8'h00;
         wa <= flash_addr;
         wact <= 1;
      end else if (wact) begin
         wact <= 0;
         if (setup) begin
            setup <= 0;
            smode <= 1;
            nops <= nops + 1;
            cnt <= BUSY;
            if (bad_seq || (wd != 8'h01 && wd != 8'hf1)) err <= err | 8'h30;
            else if (low_supply) err <= err | 8'h18;
            else if (!override_high_level && (wd == 8'hf1 || master)) err <= err | 8'h12;
            else if (wd == 8'hf1) master <= 1;
         end else begin
            if (wd == 8'h60) setup <= 1;
            if (wd == 8'h50) err <= 8'h00;
            if (wd == 8'hff) smode <= 0;
            if (wd == 8'h70) smode <= 1;
         end
      end
   end
endmodule

// *** bench/tb_fls_ctrl.sv ***
// Self-checking bench: APB-driven lock sequences against the flash model
`timescale 1ns/100ps
`include "fls_cfg.svh"
module tb_fls_ctrl;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        override_high_level = 0, bad_seq = 0, low_supply = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, irq, dq_oe, ce_n, we_n, oe_n, done_n;
   logic [20:0] faddr, ba;
   logic [7:0]  dq_out, dq_in;
   logic [33:0] expq[$], ex;
   int          n_errors = 0, checked = 0, cyc = 0;
   always #12.5 pclk = ~pclk;
   fls_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .flash_addr(faddr),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
      .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .done_line_n(done_n));
   fls_flash_model #(.BUSY(20)) FLASH (.pclk(pclk), .flash_addr(faddr),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n),
      .flash_we_n(we_n), .flash_oe_n(oe_n), .done_line_n(done_n),
      .override_high_level(override_high_level), .bad_seq(bad_seq),
      .low_supply(low_supply));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [33:0] e);
      if (!w) expq.push_back(e);
      @(posedge pclk);
      psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] d);
      apb(a, 0, 0, {2'b10, d});
   endtask
   // Polls until idle; only the bench timeout ends a hung wait
   task automatic run(input logic [31:0] c);
      apb(`FLS_REG_CTRL, 1, c, 0);
      do begin
         apb(`FLS_REG_CTRL, 0, 0, 0);
      end while (rd[0] !== 1'b0);
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
         ex = expq.pop_front();
         if (ex[33]) chk("prdata", ex[31:0], prdata);
         if (ex[33]) chk("pslverr", {31'h0, ex[32]}, {31'h0, pslverr});
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      void'($urandom(96));
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rchk(`FLS_REG_STAT, 32'h100);
      rchk(`FLS_REG_IRQ, 32'h0);
      apb(12'h020, 0, 0, {2'b11, 32'h0});
      ba = 21'($urandom);
      apb(`FLS_REG_ADDR, 1, {11'h0, ba}, 0);
      rchk(`FLS_REG_ADDR, {11'h0, ba});
      // Second go lands while busy and must be refused
      apb(`FLS_REG_CTRL, 1, 1, 0);
      run(1);
      chk("confirm address", {11'h0, ba}, {11'h0, FLASH.wa});
      chk("lock ops", 1, FLASH.nops);
      rchk(`FLS_REG_FSTAT, 32'h80);
      rchk(`FLS_REG_STAT, 32'h100);
      rchk(`FLS_REG_IRQ, 32'h1);
      apb(`FLS_REG_MASK, 1, 1, 0);
      rchk(`FLS_REG_MASK, 32'h1);
      @(posedge pclk);
      chk("irq", 1, {31'h0, irq});
      apb(`FLS_REG_IRQ, 1, 3, 0);
      @(posedge pclk);
      chk("irq", 0, {31'h0, irq});
      override_high_level <= 1;
      run(3);
      override_high_level <= 0;
      run(1);
      rchk(`FLS_REG_FSTAT, 32'h92);
      run(1);
      rchk(`FLS_REG_STAT, 32'h112);
      run(4);
      rchk(`FLS_REG_STAT, 32'h100);
      run(1);
      rchk(`FLS_REG_STAT, 32'h112);
      run(4);
      low_supply <= 1;
      run(1);
      low_supply <= 0;
      rchk(`FLS_REG_STAT, 32'h118);
      run(4);
      bad_seq <= 1;
      run(3);
      bad_seq <= 0;
      rchk(`FLS_REG_STAT, 32'h330);
      rchk(`FLS_REG_IRQ, 32'h3);
      run(8);
      chk("array mode", 0, {31'h0, FLASH.smode});
      final_report;
   end
endmodule
